// ### rtl/ebs_pkg.sv
package ebs_pkg;

    // Instruction groups that share one extended-mode bus sequence.
    typedef enum logic [3:0] {
        KIND_JUMP_ABS,
        KIND_ACC_READ,
        KIND_ACC_STORE,
        KIND_LOAD_PAIR,
        KIND_STORE_PAIR,
        KIND_LOAD_INDEX_Y,
        KIND_STORE_INDEX_Y,
        KIND_READ_MOD_WRITE,
        KIND_TEST_MEMORY,
        KIND_ARITH_PAIR,
        KIND_COMPARE_PREFIXED,
        KIND_CALL_SUB
    } ebs_kind_e;

    // Bus cycles per instruction group.
    localparam logic [2:0] LEN_JUMP_ABS      = 3'h3;
    localparam logic [2:0] LEN_ACC           = 3'h4;
    localparam logic [2:0] LEN_PAIR          = 3'h5;
    localparam logic [2:0] LEN_INDEX_Y       = 3'h6;
    localparam logic [2:0] LEN_RMW           = 3'h6;
    localparam logic [2:0] LEN_TEST          = 3'h6;
    localparam logic [2:0] LEN_ARITH_PAIR    = 3'h6;
    localparam logic [2:0] LEN_COMPARE_PFX   = 3'h7;
    localparam logic [2:0] LEN_CALL_SUB      = 3'h6;

    // Cycle that fetches the low address byte without prefix, prefix size.
    localparam logic [2:0] ADDR_LO_CYCLE     = 3'h3;
    localparam logic [2:0] PREFIX_CYCLES     = 3'h1;
    localparam logic [2:0] IDLE_CYCLE        = 3'h0;
    localparam logic [2:0] FIRST_CYCLE       = 3'h1;

    // Dummy-read address and return-address offset of call_sub.
    localparam logic [15:0] DUMMY_ADDR       = 16'hffff;
    localparam logic [15:0] CALL_RET_OFFSET  = 16'h0003;

    // Reset values.
    localparam logic [15:0] RESET_ADDR       = 16'hffff;
    localparam logic        RESET_RNW        = 1'b1;

endpackage

// ### rtl/ebs_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - jump_abs takes three reads: opcode, target high, target low.
// - Effective address comes from the two bytes after the opcode, high first.
// - Byte accumulator reads read the operand at the address in cycle four.
// - Stores write low; byte stores four cycles, pair stores five, high first.
// - Pair loads read high at address, low at address plus one, five cycles.
// - load_index_y: prefix, second opcode, two address bytes, two operand reads.
// - store_index_y: four reads, then writes of high and low bytes.
// - Read-modify-write: read, dummy read at FFFF, write result; six cycles.
// - test_memory: operand read, then two dummy reads at FFFF, no write.
// - Pair arithmetic and compare: high, low, then one dummy read.
// - Prefixed pair compares: seven reads ending in a dummy read.
// - call_sub cycle four reads the first opcode at the subroutine address.
// - call_sub then writes return low at stack pointer, high at pointer minus one.
module ebs_sequencer
    import ebs_pkg::*;
(
    // Clock and reset.
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // Instruction request.
    input  wire logic        i_start,
    input  wire ebs_kind_e   i_kind,
    input  wire logic [15:0] i_pc,
    input  wire logic [15:0] i_sp,
    input  wire logic [7:0]  i_acc,
    input  wire logic [15:0] i_reg16,
    input  wire logic [7:0]  i_result,
    output logic             o_ready,
    output logic             o_done,
    // CPU bus.
    output logic [15:0]      o_addr,
    output logic             o_rnw,
    output logic [7:0]       o_wdata,
    input  wire logic [7:0]  i_rdata,
    // Sequence status.
    output logic             o_busy,
    output logic [2:0]       o_cycle,
    output logic [15:0]      o_ea,
    output logic [15:0]      o_operand
);

    typedef struct packed {
        ebs_kind_e   kind;
        logic [2:0]  cnt;
        logic [15:0] pc;
        logic [15:0] sp;
        logic [7:0]  acc;
        logic [15:0] reg16;
        logic [15:0] ea;
        logic [15:0] opnd;
        logic [15:0] addr;
        logic        rnw;
        logic [7:0]  wdata;
        logic        dummy;
        logic        done;
    } ebs_state_s;

    ebs_state_s  r_reg;
    ebs_state_s  r_next;
    logic [2:0]  pre;
    logic [2:0]  fetch_end;
    logic [2:0]  len;
    logic [2:0]  nc;
    logic [2:0]  dn;
    logic [15:0] ret_addr;

    // Prefixed instructions push every later cycle back by one.
    assign pre = (r_reg.kind == KIND_LOAD_INDEX_Y ||
                  r_reg.kind == KIND_STORE_INDEX_Y ||
                  r_reg.kind == KIND_COMPARE_PREFIXED) ? PREFIX_CYCLES : 3'h0;
    assign fetch_end = ADDR_LO_CYCLE + pre;
    assign ret_addr  = r_reg.pc + CALL_RET_OFFSET;

    always_comb begin
        case (r_reg.kind)
            KIND_JUMP_ABS:         len = LEN_JUMP_ABS;
            KIND_ACC_READ:         len = LEN_ACC;
            KIND_ACC_STORE:        len = LEN_ACC;
            KIND_LOAD_PAIR:        len = LEN_PAIR;
            KIND_STORE_PAIR:       len = LEN_PAIR;
            KIND_LOAD_INDEX_Y:     len = LEN_INDEX_Y;
            KIND_STORE_INDEX_Y:    len = LEN_INDEX_Y;
            KIND_READ_MOD_WRITE:   len = LEN_RMW;
            KIND_TEST_MEMORY:      len = LEN_TEST;
            KIND_ARITH_PAIR:       len = LEN_ARITH_PAIR;
            KIND_COMPARE_PREFIXED: len = LEN_COMPARE_PFX;
            KIND_CALL_SUB:         len = LEN_CALL_SUB;
            default:               len = LEN_JUMP_ABS;
        endcase
    end

    // The bus outputs are registered, so each branch below computes the
    // access of the coming cycle from the byte read in the present one.
    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        nc          = r_reg.cnt + 3'h1;
        dn          = nc - fetch_end;
        if (r_reg.cnt == IDLE_CYCLE) begin
            r_next.addr  = DUMMY_ADDR;
            r_next.rnw   = 1'b1;
            r_next.wdata = 8'h00;
            r_next.dummy = 1'b1;
            if (i_start) begin
                r_next.kind  = i_kind;
                r_next.pc    = i_pc;
                r_next.sp    = i_sp;
                r_next.acc   = i_acc;
                r_next.reg16 = i_reg16;
                r_next.ea    = 16'h0000;
                r_next.opnd  = 16'h0000;
                r_next.cnt   = FIRST_CYCLE;
                r_next.addr  = i_pc;
                r_next.dummy = 1'b0;
            end
        end else begin
            if (r_reg.cnt == fetch_end - 3'h1) begin
                r_next.ea[15:8] = i_rdata;
            end
            if (r_reg.cnt == fetch_end) begin
                r_next.ea[7:0] = i_rdata;
            end
            // Real data reads shift in, so a pair ends high byte first.
            if (r_reg.cnt > fetch_end && r_reg.rnw && !r_reg.dummy) begin
                r_next.opnd = {r_reg.opnd[7:0], i_rdata};
            end
            r_next.rnw   = 1'b1;
            r_next.wdata = 8'h00;
            r_next.dummy = 1'b0;
            if (r_reg.cnt == len) begin
                r_next.cnt   = IDLE_CYCLE;
                r_next.done  = 1'b1;
                r_next.addr  = DUMMY_ADDR;
                r_next.dummy = 1'b1;
            end else begin
                r_next.cnt = nc;
                if (nc <= fetch_end) begin
                    r_next.addr = r_reg.pc + {13'h0000, nc} - 16'h0001;
                end else begin
                    case (r_reg.kind)
                        KIND_ACC_READ: begin
                            r_next.addr = r_next.ea;
                        end
                        KIND_ACC_STORE: begin
                            r_next.addr  = r_next.ea;
                            r_next.rnw   = 1'b0;
                            r_next.wdata = r_reg.acc;
                        end
                        KIND_LOAD_PAIR, KIND_LOAD_INDEX_Y: begin
                            r_next.addr = (dn == 3'h1) ? r_next.ea
                                                       : r_next.ea + 16'h0001;
                        end
                        KIND_STORE_PAIR, KIND_STORE_INDEX_Y: begin
                            r_next.addr  = (dn == 3'h1) ? r_next.ea
                                                        : r_next.ea + 16'h0001;
                            r_next.rnw   = 1'b0;
                            r_next.wdata = (dn == 3'h1) ? r_reg.reg16[15:8]
                                                        : r_reg.reg16[7:0];
                        end
                        KIND_READ_MOD_WRITE: begin
                            if (dn == 3'h2) begin
                                r_next.addr  = DUMMY_ADDR;
                                r_next.dummy = 1'b1;
                            end else begin
                                r_next.addr = r_next.ea;
                            end
                            if (dn == 3'h3) begin
                                r_next.rnw   = 1'b0;
                                r_next.wdata = i_result;
                            end
                        end
                        KIND_TEST_MEMORY: begin
                            r_next.addr  = (dn == 3'h1) ? r_next.ea
                                                        : DUMMY_ADDR;
                            r_next.dummy = (dn != 3'h1);
                        end
                        KIND_ARITH_PAIR, KIND_COMPARE_PREFIXED: begin
                            if (dn == 3'h1) begin
                                r_next.addr = r_next.ea;
                            end else if (dn == 3'h2) begin
                                r_next.addr = r_next.ea + 16'h0001;
                            end else begin
                                r_next.addr  = DUMMY_ADDR;
                                r_next.dummy = 1'b1;
                            end
                        end
                        KIND_CALL_SUB: begin
                            if (dn == 3'h1) begin
                                r_next.addr = r_next.ea;
                            end else if (dn == 3'h2) begin
                                r_next.addr  = r_reg.sp;
                                r_next.rnw   = 1'b0;
                                r_next.wdata = ret_addr[7:0];
                            end else begin
                                r_next.addr  = r_reg.sp - 16'h0001;
                                r_next.rnw   = 1'b0;
                                r_next.wdata = ret_addr[15:8];
                            end
                        end
                        default: begin
                            r_next.addr  = DUMMY_ADDR;
                            r_next.dummy = 1'b1;
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            r_reg      <= '0;
            r_reg.addr <= RESET_ADDR;
            r_reg.rnw  <= RESET_RNW;
        end else begin
            r_reg <= r_next;
        end
    end

    // A new request waits for idle, which costs one cycle between them.
    assign o_ready   = (r_reg.cnt == IDLE_CYCLE);
    assign o_done    = r_reg.done;
    assign o_addr    = r_reg.addr;
    assign o_rnw     = r_reg.rnw;
    assign o_wdata   = r_reg.wdata;
    assign o_busy    = (r_reg.cnt != IDLE_CYCLE);
    assign o_cycle   = r_reg.cnt;
    assign o_ea      = r_reg.ea;
    assign o_operand = r_reg.opnd;

    jump_length_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_ready && i_start && i_kind == KIND_JUMP_ABS
        |=> (o_busy && o_rnw) [*3] ##1 !o_busy)
        else $error("jump_abs did not take three read cycles");

    addr_fetch_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && o_cycle <= fetch_end
        |-> o_rnw && o_addr == r_reg.pc + {13'h0000, o_cycle} - 16'h0001)
        else $error("opcode or address byte fetched from wrong address");

    acc_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_ready && i_start && i_kind == KIND_ACC_READ
        |-> ##4 (o_cycle == 3'h4 && o_rnw && o_addr == o_ea) ##1 !o_busy)
        else $error("byte operand read not at effective address in cycle four");

    store_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && o_cycle > 3'h3 && (r_reg.kind == KIND_STORE_PAIR ||
        r_reg.kind == KIND_ACC_STORE)
        |-> !o_rnw)
        else $error("store data cycle is not a write");

    pair_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && r_reg.kind == KIND_LOAD_PAIR && o_cycle == 3'h4
        |-> o_addr == o_ea ##1 (o_rnw && o_addr == $past(o_addr) + 16'h0001))
        else $error("pair load not read at consecutive addresses");

    index_y_len_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_ready && i_start && i_kind == KIND_LOAD_INDEX_Y
        |=> (o_busy && o_rnw) [*6] ##1 !o_busy)
        else $error("load_index_y did not take six reads");

    index_y_store_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && r_reg.kind == KIND_STORE_INDEX_Y && o_cycle == 3'h6
        |-> !o_rnw && o_wdata == r_reg.reg16[7:0]
            && $past(o_wdata) == r_reg.reg16[15:8])
        else $error("store_index_y write bytes wrong");

    rmw_order_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && r_reg.kind == KIND_READ_MOD_WRITE && o_cycle == 3'h5
        |-> o_addr == DUMMY_ADDR && o_rnw
            ##1 !o_rnw && o_addr == o_ea && o_wdata == $past(i_result))
        else $error("read-modify-write sequence wrong");

    test_nowrite_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && r_reg.kind == KIND_TEST_MEMORY && o_cycle > 3'h4
        |-> o_rnw && o_addr == DUMMY_ADDR)
        else $error("test_memory wrote or missed a dummy read");

    arith_dummy_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && r_reg.kind == KIND_ARITH_PAIR && o_cycle == 3'h6
        |-> o_rnw && o_addr == DUMMY_ADDR ##1 !o_busy)
        else $error("pair arithmetic final dummy read missing");

    compare_len_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_ready && i_start && i_kind == KIND_COMPARE_PREFIXED
        |=> (o_busy && o_rnw) [*7] ##1 !o_busy)
        else $error("prefixed compare did not take seven reads");

    call_stack_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy && r_reg.kind == KIND_CALL_SUB && o_cycle == 3'h4
        |-> o_rnw && o_addr == o_ea
            ##1 !o_rnw && o_addr == r_reg.sp && o_wdata == ret_addr[7:0]
            ##1 !o_rnw && o_addr == r_reg.sp - 16'h0001)
        else $error("call_sub stack writes wrong");

    cycle_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_busy |=> o_cycle == $past(o_cycle) + 3'h1 || (o_done && !o_busy))
        else $error("cycle counter did not advance by one");

endmodule // ebs_sequencer

// ### verification/ebs_mem.sv
`timescale 1ns/1ps
// Byte-wide memory on the far side of the CPU bus. A read answers at once.
// The bus has no wait states, so the model cannot answer slowly.
module ebs_mem (
    // Clock.
    input  wire logic        i_clk,
    // CPU bus.
    input  wire logic [15:0] i_addr,
    input  wire logic        i_rnw,
    input  wire logic [7:0]  i_wdata,
    output logic [7:0]       o_rdata
);
    logic [7:0] mem [65536];

    // Every place holds a defined byte, so dummy reads see real data too.
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
        end
    end

    assign o_rdata = mem[i_addr];

    always @(posedge i_clk) begin
        if (i_rnw === 1'b0) begin
            mem[i_addr] <= i_wdata;
        end
    end
endmodule // ebs_mem

// ### verification/extended_mode_bus_cycle_sequencer_tb.sv
`timescale 1ns/1ps
module extended_mode_bus_cycle_sequencer_tb;
    import ebs_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_start = 1'b0;
    ebs_kind_e   i_kind = KIND_JUMP_ABS;
    logic [15:0] i_pc = 16'h0000;
    logic [15:0] i_sp = 16'h0000;
    logic [7:0]  i_acc = 8'h00;
    logic [15:0] i_reg16 = 16'h0000;
    logic [7:0]  i_result = 8'h00;
    logic        o_ready, o_done, o_rnw, o_busy;
    logic [15:0] o_addr, o_ea, o_operand;
    logic [7:0]  o_wdata, rdata;
    logic [2:0]  o_cycle;
    logic [15:0] qa [$];
    logic        qr [$];
    logic [7:0]  qw [$];
    int          seed, fails, checked;

    always #5 i_clk = ~i_clk;

    ebs_sequencer dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_start(i_start),
        .i_kind(i_kind), .i_pc(i_pc), .i_sp(i_sp), .i_acc(i_acc),
        .i_reg16(i_reg16), .i_result(i_result), .o_ready(o_ready),
        .o_done(o_done), .o_addr(o_addr), .o_rnw(o_rnw), .o_wdata(o_wdata),
        .i_rdata(rdata), .o_busy(o_busy), .o_cycle(o_cycle), .o_ea(o_ea),
        .o_operand(o_operand));

    ebs_mem u_mem (.i_clk(i_clk), .i_addr(o_addr), .i_rnw(o_rnw),
        .i_wdata(o_wdata), .o_rdata(rdata));

    task automatic test_done;
        if (fails == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic add(input logic [15:0] a, input logic r,
                       input logic [7:0] w);
        qa.push_back(a);
        qr.push_back(r);
        qw.push_back(w);
    endtask

    // One instruction; entered and left at a falling edge with ready high.
    task automatic run(input ebs_kind_e k);
        logic [15:0] pc, sp, ea, rg, op, ret;
        logic [7:0]  acc, res;
        int          pre, i, last;
        logic        chkop;
        pc = 16'($random(seed));
        sp = 16'($random(seed));
        ea = 16'($random(seed));
        rg = 16'($random(seed));
        acc = 8'($random(seed));
        res = 8'($random(seed));
        pre = (k == KIND_LOAD_INDEX_Y || k == KIND_STORE_INDEX_Y ||
               k == KIND_COMPARE_PREFIXED) ? 1 : 0;
        u_mem.mem[16'(pc + 16'(pre + 1))] = ea[15:8];
        u_mem.mem[16'(pc + 16'(pre + 2))] = ea[7:0];
        ret = pc + 16'h0003;
        op = {8'h00, u_mem.mem[ea]};
        chkop = 1'b1;
        qa.delete();
        qr.delete();
        qw.delete();
        for (i = 0; i <= 2 + pre; i++) add(pc + 16'(i), 1'b1, 8'h00);
        case (k)
            KIND_ACC_READ: add(ea, 1'b1, 8'h00);
            KIND_ACC_STORE: add(ea, 1'b0, acc);
            KIND_LOAD_PAIR, KIND_LOAD_INDEX_Y: begin
                add(ea, 1'b1, 8'h00);
                add(ea + 16'h1, 1'b1, 8'h00);
            end
            KIND_STORE_PAIR, KIND_STORE_INDEX_Y: begin
                add(ea, 1'b0, rg[15:8]);
                add(ea + 16'h1, 1'b0, rg[7:0]);
            end
            KIND_READ_MOD_WRITE: begin
                add(ea, 1'b1, 8'h00);
                add(16'hffff, 1'b1, 8'h00);
                add(ea, 1'b0, res);
            end
            KIND_TEST_MEMORY: begin
                add(ea, 1'b1, 8'h00);
                add(16'hffff, 1'b1, 8'h00);
                add(16'hffff, 1'b1, 8'h00);
            end
            KIND_ARITH_PAIR, KIND_COMPARE_PREFIXED: begin
                add(ea, 1'b1, 8'h00);
                add(ea + 16'h1, 1'b1, 8'h00);
                add(16'hffff, 1'b1, 8'h00);
            end
            KIND_CALL_SUB: begin
                add(ea, 1'b1, 8'h00);
                add(sp, 1'b0, ret[7:0]);
                add(sp - 16'h1, 1'b0, ret[15:8]);
            end
            default: chkop = 1'b0;
        endcase
        if (k == KIND_LOAD_PAIR || k == KIND_LOAD_INDEX_Y ||
            k == KIND_ARITH_PAIR || k == KIND_COMPARE_PREFIXED) begin
            op = {u_mem.mem[ea], u_mem.mem[16'(ea + 16'h1)]};
        end
        if (k == KIND_ACC_STORE || k == KIND_STORE_PAIR ||
            k == KIND_STORE_INDEX_Y) begin
            chkop = 1'b0;
        end
        i_kind = k;
        i_pc = pc;
        i_sp = sp;
        i_acc = acc;
        i_reg16 = rg;
        i_result = res;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        i = 0;
        while (o_cycle !== 3'h1 && i < 4) begin
            @(negedge i_clk);
            i++;
        end
        if (i == 4) begin
            fails++;
            test_done;
        end
        last = qa.size() - 1;
        for (i = 0; i <= last; i++) begin
            chk("cycle", 16'(i + 1), {13'h0, o_cycle});
            chk("addr", qa[i], o_addr);
            chk("rnw", {15'h0, qr[i]}, {15'h0, o_rnw});
            chk("wdata", {8'h00, qw[i]}, {8'h00, o_wdata});
            chk("ready", 16'h0, {15'h0, o_ready});
            chk("busy", 16'h1, {15'h0, o_busy});
            if (i >= 1) begin
                // Requests in mid-sequence must be ignored.
                i_start = (i < last);
                i_kind = KIND_JUMP_ABS;
                i_pc = ~pc;
                i_sp = ~sp;
                i_reg16 = ~rg;
                i_acc = ~acc;
            end
            @(negedge i_clk);
        end
        chk("done", 16'h1, {15'h0, o_done});
        chk("idle addr", 16'hffff, o_addr);
        chk("idle busy", 16'h0, {15'h0, o_busy});
        chk("idle ready", 16'h1, {15'h0, o_ready});
        chk("idle rnw", 16'h1, {15'h0, o_rnw});
        chk("ea", ea, o_ea);
        if (chkop) begin
            chk("operand", op, o_operand);
        end
    endtask

    // Reset in mid-instruction returns the bus, o_busy, o_done and o_cycle to idle and clears o_ea.
    task automatic reset_mid;
        i_kind = KIND_CALL_SUB;
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rstn = 1'b0;
        #1;
        chk("rst addr", 16'hffff, o_addr);
        chk("rst rnw", 16'h1, {15'h0, o_rnw});
        chk("rst state", 16'h0, {o_busy, o_done, o_wdata, 3'h0, o_cycle});
        chk("rst ea", 16'h0, o_ea);
        @(negedge i_clk);
        i_rstn = 1'b1;
        @(negedge i_clk);
    endtask

    initial begin
        seed = 88;
        fails = 0;
        checked = 0;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_rstn = 1'b1;
        @(negedge i_clk);
        for (int it = 0; it < 60; it++) begin
            run(ebs_kind_e'(it % 12));
        end
        reset_mid();
        run(KIND_CALL_SUB);
        run(KIND_READ_MOD_WRITE);
        test_done;
    end
endmodule // extended_mode_bus_cycle_sequencer_tb
